// [shared/char_display_consts.svh]
// Constants of the character display instruction executor
`ifndef CHAR_DISPLAY_CONSTS_SVH
`define CHAR_DISPLAY_CONSTS_SVH

// Character and address constants
`define SPACE_CODE 8'h20
`define TEXT_ADDR_HOME 7'h00
`define TEXT_LINE1_LAST 7'h27
`define TEXT_LINE2_FIRST 7'h40
`define TEXT_LINE2_LAST 7'h67
`define GLYPH_ADDR_FIRST 6'h00
`define GLYPH_ADDR_LAST 6'h3f
`define SHIFT_HOME 6'h00
`define SHIFT_LAST 6'h27

// Field positions inside command bytes
`define ENTRY_INC_BIT 1
`define ENTRY_SHIFT_BIT 0
`define DISP_ON_BIT 2
`define DISP_CURSOR_BIT 1
`define DISP_BLINK_BIT 0
`define MOVE_TARGET_BIT 3
`define MOVE_DIR_BIT 2
`define FUNC_WIDTH_BIT 4
`define FUNC_LINES_BIT 3
`define FUNC_BRIGHT_MSB 1
`define FUNC_BRIGHT_LSB 0

// Reset values
`define RST_INC 1'b1
`define RST_AUTO_SHIFT 1'b0
`define RST_DISP_ON 1'b0
`define RST_CURSOR_ON 1'b0
`define RST_BLINK_ON 1'b0
`define RST_BUS8 1'b1
`define RST_TWO_LINES 1'b1
`define RST_BRIGHT 2'h0

// Timing
`define CLK_FREQ_KHZ 10000
`define BLINK_HALF_MS 500

`endif

// [shared/char_display_pkg.sv]
// Types of the character display instruction executor
package char_display_pkg;

	// Decoded command of one assembled byte
	typedef enum logic [3:0] {
		CMD_NONE = 4'b0000,
		CMD_CLEAR = 4'b0001,
		CMD_HOME = 4'b0010,
		CMD_ENTRY = 4'b0011,
		CMD_DISPLAY = 4'b0100,
		CMD_MOVE = 4'b0101,
		CMD_FUNCTION = 4'b0110,
		CMD_GLYPH_ADDR = 4'b0111,
		CMD_TEXT_ADDR = 4'b1000
	} cmd_t;

	// Whole state of the executor
	typedef struct packed {
		logic [127:0][7:0] text_ram;
		logic [63:0][7:0] glyph_ram;
		logic [6:0] address_counter;
		logic glyph_sel;
		logic inc;
		logic auto_shift;
		logic disp_on;
		logic cursor_on;
		logic blink_on;
		logic bus8;
		logic two_lines;
		logic [1:0] brightness_level;
		logic [5:0] shift_off;
		logic nib_phase;
		logic [3:0] nib_hi;
		logic [7:0] rd_hold;
		logic [7:0] rd_data;
		logic [23:0] blink_cnt;
		logic blink_phase;
		logic [1:0] pwm_cnt;
		logic panel_gate;
	} state_t;

endpackage

// [core/char_display_instruction_executor.sv]
// Instruction executor of a 16x2 character display controller
`timescale 1ns/1ps
`include "char_display_consts.svh"

module char_display_instruction_executor
	import char_display_pkg::*;
#(
	parameter int BLINK_HALF_CYCLES = `BLINK_HALF_MS * `CLK_FREQ_KHZ
) (
	input wire logic i_clk, // 10 MHz clock
	input wire logic i_rst, // Async reset, high
	input wire logic i_register_select, // 1 data, 0 instruction
	input wire logic i_wr_strobe, // Write, one cycle
	input wire logic i_rd_strobe, // Read, one cycle
	input wire logic [7:0] i_data, // Write data lines
	output logic [7:0] o_rd_data, // Read data, cycle after
	output logic [6:0] o_address_counter, // Cursor position
	output logic o_glyph_sel, // Counter addresses glyph RAM
	output logic o_display_on, // Panel shows text
	output logic o_cursor_on, // Eighth row cursor
	output logic o_blink_all_on, // Cursor char shown all-on
	output logic [5:0] o_shift_offset, // Display shift position
	output logic o_bus_width_select, // 1 = 8-bit bus
	output logic o_two_lines, // 1 = two lines
	output logic [1:0] o_brightness_level, // Luminance code
	output logic o_panel_gate // Panel drive gate
);

	// Refuse a blink period the 24-bit timer cannot hold
	if (BLINK_HALF_CYCLES < 1 || BLINK_HALF_CYCLES > 24'hffffff) begin : g_bad_blink
		$error("BLINK_HALF_CYCLES out of range");
	end

	state_t st_r;
	state_t st_nxt;

	// Byte assembly strobes
	logic byte_wr;
	logic byte_rd;
	logic [7:0] wr_byte;
	logic [7:0] rd_byte;
	cmd_t cmd;

	function automatic logic [6:0] text_step(input logic [6:0] a, input logic up);
		if (up) begin
			if (a == `TEXT_LINE1_LAST) begin
				return `TEXT_LINE2_FIRST;
			end else if (a == `TEXT_LINE2_LAST) begin
				return `TEXT_ADDR_HOME;
			end else begin
				return a + 7'h01;
			end
		end else begin
			if (a == `TEXT_LINE2_FIRST) begin
				return `TEXT_LINE1_LAST;
			end else if (a == `TEXT_ADDR_HOME) begin
				return `TEXT_LINE2_LAST;
			end else begin
				return a - 7'h01;
			end
		end
	endfunction

	function automatic logic [5:0] glyph_step(input logic [5:0] a, input logic up);
		if (up) begin
			return (a == `GLYPH_ADDR_LAST) ? `GLYPH_ADDR_FIRST : a + 6'h01;
		end else begin
			return (a == `GLYPH_ADDR_FIRST) ? `GLYPH_ADDR_LAST : a - 6'h01;
		end
	endfunction

	// Left shift shows higher addresses, so the offset grows
	function automatic logic [5:0] shift_move(input logic [5:0] s, input logic left);
		if (left) begin
			return (s == `SHIFT_LAST) ? `SHIFT_HOME : s + 6'h01;
		end else begin
			return (s == `SHIFT_HOME) ? `SHIFT_LAST : s - 6'h01;
		end
	endfunction

	// Step after a data access in the selected RAM
	function automatic logic [6:0] access_step(input state_t s);
		if (s.glyph_sel) begin
			return {1'b0, glyph_step(s.address_counter[5:0], s.inc)};
		end else begin
			return text_step(s.address_counter, s.inc);
		end
	endfunction

	// In 4-bit mode only the second nibble completes a byte
	assign byte_wr = i_wr_strobe && (st_r.bus8 || st_r.nib_phase);
	assign byte_rd = i_rd_strobe && (st_r.bus8 || st_r.nib_phase);
	assign wr_byte = st_r.bus8 ? i_data : {st_r.nib_hi, i_data[7:4]};

	// Byte a read returns; busy flag is always zero
	always_comb begin
		if (i_register_select) begin
			if (st_r.glyph_sel) begin
				rd_byte = st_r.glyph_ram[st_r.address_counter[5:0]];
			end else begin
				rd_byte = st_r.text_ram[st_r.address_counter];
			end
		end else begin
			rd_byte = {1'b0, st_r.address_counter};
		end
	end

	// Command decode; don't-care bits are wildcards
	always_comb begin
		casez (wr_byte)
			8'b1???????: cmd = CMD_TEXT_ADDR;
			8'b01??????: cmd = CMD_GLYPH_ADDR;
			8'b001?????: cmd = CMD_FUNCTION;
			8'b0001????: cmd = CMD_MOVE;
			8'b00001???: cmd = CMD_DISPLAY;
			8'b000001??: cmd = CMD_ENTRY;
			8'b0000001?: cmd = CMD_HOME;
			8'b00000001: cmd = CMD_CLEAR;
			default: cmd = CMD_NONE;
		endcase
	end

	always_comb begin
		st_nxt = st_r;

		// Nibble pairing
		if (!st_r.bus8 && (i_wr_strobe || i_rd_strobe)) begin
			st_nxt.nib_phase = !st_r.nib_phase;
		end
		if (!st_r.bus8 && i_wr_strobe && !st_r.nib_phase) begin
			st_nxt.nib_hi = i_data[7:4];
		end

		// Reads: whole byte or high nibble first, low nibble second
		if (i_rd_strobe) begin
			if (st_r.bus8) begin
				st_nxt.rd_data = rd_byte;
			end else if (!st_r.nib_phase) begin
				st_nxt.rd_hold = rd_byte;
				st_nxt.rd_data = {rd_byte[7:4], 4'h0};
			end else begin
				st_nxt.rd_data = {st_r.rd_hold[3:0], 4'h0};
			end
		end

		// Data read steps the counter but never shifts
		if (byte_rd && i_register_select) begin
			st_nxt.address_counter = access_step(st_r);
		end

		// Data write into the RAM chosen by glyph_sel, set by a glyph address set and cleared by clear, home, move or a text address set
		if (byte_wr && i_register_select) begin
			if (st_r.glyph_sel) begin
				st_nxt.glyph_ram[st_r.address_counter[5:0]] = wr_byte;
			end else begin
				st_nxt.text_ram[st_r.address_counter] = wr_byte;
				if (st_r.auto_shift) begin
					st_nxt.shift_off = shift_move(st_r.shift_off, st_r.inc);
				end
			end
			st_nxt.address_counter = access_step(st_r);
		end

		// Instructions execute in the cycle they complete
		if (byte_wr && !i_register_select) begin
			case (cmd)
				CMD_CLEAR: begin
					st_nxt.text_ram = {128{`SPACE_CODE}};
					st_nxt.address_counter = `TEXT_ADDR_HOME;
					st_nxt.glyph_sel = 1'b0;
					st_nxt.shift_off = `SHIFT_HOME;
					st_nxt.inc = 1'b1;
				end
				CMD_HOME: begin
					st_nxt.address_counter = `TEXT_ADDR_HOME;
					st_nxt.glyph_sel = 1'b0;
					st_nxt.shift_off = `SHIFT_HOME;
				end
				CMD_ENTRY: begin
					st_nxt.inc = wr_byte[`ENTRY_INC_BIT];
					st_nxt.auto_shift = wr_byte[`ENTRY_SHIFT_BIT];
				end
				CMD_DISPLAY: begin
					st_nxt.disp_on = wr_byte[`DISP_ON_BIT];
					st_nxt.cursor_on = wr_byte[`DISP_CURSOR_BIT];
					st_nxt.blink_on = wr_byte[`DISP_BLINK_BIT];
				end
				CMD_MOVE: begin
					// Glyph address is reinterpreted as a text address
					st_nxt.glyph_sel = 1'b0;
					st_nxt.address_counter = text_step(st_r.address_counter,
						wr_byte[`MOVE_DIR_BIT]);
					if (wr_byte[`MOVE_TARGET_BIT]) begin
						st_nxt.shift_off = shift_move(st_r.shift_off,
							!wr_byte[`MOVE_DIR_BIT]);
					end
				end
				CMD_FUNCTION: begin
					st_nxt.bus8 = wr_byte[`FUNC_WIDTH_BIT];
					st_nxt.two_lines = wr_byte[`FUNC_LINES_BIT];
					st_nxt.brightness_level = wr_byte[`FUNC_BRIGHT_MSB:`FUNC_BRIGHT_LSB];
					st_nxt.nib_phase = 1'b0;
				end
				CMD_GLYPH_ADDR: begin
					st_nxt.address_counter = {1'b0, wr_byte[5:0]};
					st_nxt.glyph_sel = 1'b1;
				end
				CMD_TEXT_ADDR: begin
					st_nxt.address_counter = wr_byte[6:0];
					st_nxt.glyph_sel = 1'b0;
				end
				default: begin
				end
			endcase
		end

		// Blink timer restarts whenever blinking is off
		if (!st_r.blink_on) begin
			st_nxt.blink_cnt = 24'h000000;
			st_nxt.blink_phase = 1'b0;
		end else if (st_r.blink_cnt == 24'(BLINK_HALF_CYCLES - 1)) begin
			st_nxt.blink_cnt = 24'h000000;
			st_nxt.blink_phase = !st_r.blink_phase;
		end else begin
			st_nxt.blink_cnt = st_r.blink_cnt + 24'h000001;
		end

		// Four-slot duty: code 0 full, 1 three, 2 two, 3 one slot
		st_nxt.pwm_cnt = st_r.pwm_cnt + 2'h1;
		st_nxt.panel_gate = st_r.disp_on && (st_r.pwm_cnt >= st_r.brightness_level);
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			st_r.text_ram <= {128{`SPACE_CODE}};
			st_r.glyph_ram <= '0;
			st_r.address_counter <= `TEXT_ADDR_HOME;
			st_r.glyph_sel <= 1'b0;
			st_r.inc <= `RST_INC;
			st_r.auto_shift <= `RST_AUTO_SHIFT;
			st_r.disp_on <= `RST_DISP_ON;
			st_r.cursor_on <= `RST_CURSOR_ON;
			st_r.blink_on <= `RST_BLINK_ON;
			st_r.bus8 <= `RST_BUS8;
			st_r.two_lines <= `RST_TWO_LINES;
			st_r.brightness_level <= `RST_BRIGHT;
			st_r.shift_off <= `SHIFT_HOME;
			st_r.nib_phase <= 1'b0;
			st_r.nib_hi <= 4'h0;
			st_r.rd_hold <= 8'h00;
			st_r.rd_data <= 8'h00;
			st_r.blink_cnt <= 24'h000000;
			st_r.blink_phase <= 1'b0;
			st_r.pwm_cnt <= 2'h0;
			st_r.panel_gate <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign o_rd_data = st_r.rd_data;
	assign o_address_counter = st_r.address_counter;
	assign o_glyph_sel = st_r.glyph_sel;
	assign o_display_on = st_r.disp_on;
	assign o_cursor_on = st_r.cursor_on;
	assign o_blink_all_on = st_r.blink_on && st_r.blink_phase;
	assign o_shift_offset = st_r.shift_off;
	assign o_bus_width_select = st_r.bus8;
	assign o_two_lines = st_r.two_lines;
	assign o_brightness_level = st_r.brightness_level;
	assign o_panel_gate = st_r.panel_gate;

	// Checks
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_clear_cmd;
		byte_wr && !i_register_select && cmd == CMD_CLEAR;
	endsequence

	sequence s_home_cmd;
		byte_wr && !i_register_select && cmd == CMD_HOME;
	endsequence

	sequence s_first_nibble;
		!st_r.bus8 && i_wr_strobe && !st_r.nib_phase;
	endsequence

	chk_clear_state: assert property (s_clear_cmd |=>
		st_r.address_counter == `TEXT_ADDR_HOME && st_r.shift_off == `SHIFT_HOME
		&& st_r.inc && !st_r.glyph_sel
		&& st_r.text_ram[$past(st_r.address_counter)] == `SPACE_CODE)
		else $error("clear did not reset counter, shift or text");

	chk_home_keeps: assert property (s_home_cmd |=>
		st_r.address_counter == `TEXT_ADDR_HOME && st_r.shift_off == `SHIFT_HOME
		&& st_r.inc == $past(st_r.inc) && st_r.text_ram == $past(st_r.text_ram))
		else $error("home changed wrong state");

	chk_counter_read: assert property (byte_rd && !i_register_select && st_r.bus8 |=>
		o_rd_data == {1'b0, $past(st_r.address_counter)}
		&& st_r.address_counter == $past(st_r.address_counter))
		else $error("counter read wrong or busy set");

	chk_text_wrap_up: assert property (byte_wr && i_register_select && !st_r.glyph_sel
		&& st_r.inc && st_r.address_counter == `TEXT_LINE1_LAST |=>
		st_r.address_counter == `TEXT_LINE2_FIRST)
		else $error("text counter did not cross line gap");

	chk_text_wrap_down: assert property (byte_rd && i_register_select && !st_r.glyph_sel
		&& !st_r.inc && st_r.address_counter == `TEXT_ADDR_HOME |=>
		st_r.address_counter == `TEXT_LINE2_LAST)
		else $error("text counter did not wrap down");

	chk_glyph_wrap: assert property (byte_wr && i_register_select && st_r.glyph_sel
		&& st_r.inc && st_r.address_counter[5:0] == `GLYPH_ADDR_LAST |=>
		st_r.address_counter == 7'h00 && st_r.glyph_sel)
		else $error("glyph counter did not wrap");

	chk_no_read_shift: assert property (byte_rd |=>
		st_r.shift_off == $past(st_r.shift_off))
		else $error("read moved the display");

	chk_auto_shift: assert property (byte_wr && i_register_select && !st_r.glyph_sel
		&& st_r.auto_shift && st_r.inc |=>
		st_r.shift_off == shift_move($past(st_r.shift_off), 1'b1))
		else $error("auto-shift missing on text write");

	chk_move_to_text: assert property (byte_wr && !i_register_select && cmd == CMD_MOVE
		|=> !st_r.glyph_sel && st_r.glyph_ram == $past(st_r.glyph_ram))
		else $error("cursor move left glyph selected");

	chk_nibble_pair: assert property (s_first_nibble |=>
		st_r.nib_phase && st_r.address_counter == $past(st_r.address_counter)
		&& st_r.text_ram == $past(st_r.text_ram))
		else $error("first nibble acted as a byte");

	chk_full_bright: assert property (st_r.disp_on && st_r.brightness_level == 2'h0
		&& $past(st_r.disp_on) && $past(st_r.brightness_level) == 2'h0 |->
		o_panel_gate)
		else $error("full brightness gate dropped");

	chk_blank_gate: assert property (!st_r.disp_on ##1 !st_r.disp_on |-> !o_panel_gate)
		else $error("panel driven while blank");

endmodule

// [verif/host_model.sv]
// Host side model that drives the instruction port
`timescale 1ns/1ps
module host_model (
	input wire logic i_clk, // Clock
	output logic o_register_select, // Data or instruction
	output logic o_wr_strobe, // Write pulse
	output logic o_rd_strobe, // Read pulse
	output logic [7:0] o_data // Write data lines
);
	logic [7:0] exp_q[$];
	logic bus8 = 1'b1;

	initial begin
		o_register_select = 1'b0;
		o_wr_strobe = 1'b0;
		o_rd_strobe = 1'b0;
		o_data = 8'h00;
	end

	// One strobe; lines not driven by the host show inverted junk
	task automatic cyc(input logic rs, input logic wr, input logic [7:0] d);
		@(posedge i_clk);
		o_register_select <= rs;
		o_wr_strobe <= wr;
		o_rd_strobe <= !wr;
		o_data <= wr ? d : ~o_data;
	endtask

	task automatic xfer(input logic rs, input logic wr, input logic [7:0] d);
		if (bus8) begin
			cyc(rs, wr, d);
		end else begin
			cyc(rs, wr, {d[7:4], ~d[3:0]});
			cyc(rs, wr, {d[3:0], ~d[7:4]});
		end
		if (!rs && wr && d[7:5] == 3'b001) begin
			bus8 = d[4];
		end
	endtask

	// Notes the expected read bytes, then reads
	task automatic rd(input logic rs, input logic [7:0] e);
		if (bus8) begin
			exp_q.push_back(e);
		end else begin
			exp_q.push_back({e[7:4], 4'h0});
			exp_q.push_back({e[3:0], 4'h0});
		end
		xfer(rs, 1'b0, 8'h00);
	endtask

	task automatic idle();
		@(posedge i_clk);
		o_wr_strobe <= 1'b0;
		o_rd_strobe <= 1'b0;
	endtask
endmodule

// [verif/char_display_instruction_executor_tb.sv]
// Self-checking bench of the instruction executor
`timescale 1ns/1ps
module char_display_instruction_executor_tb;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic rs, wr, rd, gsel, don, con, blink, bw, two, gate;
	logic [7:0] d, rdat, b, g;
	logic [6:0] ac;
	logic [5:0] sh;
	logic [1:0] br;
	logic rd_d = 1'b0;
	int n_errors = 0;
	int cmp_count = 0;
	int cyc_n = 0;
	int k, cnt;

	always #50 i_clk = ~i_clk;

	host_model u_host_model (.i_clk(i_clk), .o_register_select(rs), .o_wr_strobe(wr),
		.o_rd_strobe(rd), .o_data(d));

	char_display_instruction_executor #(.BLINK_HALF_CYCLES(4)) u_char_display_instruction_executor (
		.i_clk(i_clk), .i_rst(i_rst), .i_register_select(rs), .i_wr_strobe(wr),
		.i_rd_strobe(rd), .i_data(d), .o_rd_data(rdat), .o_address_counter(ac),
		.o_glyph_sel(gsel), .o_display_on(don), .o_cursor_on(con), .o_blink_all_on(blink),
		.o_shift_offset(sh), .o_bus_width_select(bw), .o_two_lines(two),
		.o_brightness_level(br), .o_panel_gate(gate));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic w(input logic s, input logic [7:0] v);
		u_host_model.xfer(s, 1'b1, v);
		u_host_model.idle();
		@(negedge i_clk);
	endtask

	task automatic r(input logic s, input logic [7:0] e);
		u_host_model.rd(s, e);
		u_host_model.idle();
		@(negedge i_clk);
	endtask

	// Read data stand from the cycle after the strobe until the next read
	always @(posedge i_clk) rd_d <= rd;
	always @(negedge i_clk) begin
		if (rd_d) begin
			chk(rdat, u_host_model.exp_q.pop_front());
		end
	end

	always @(posedge i_clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			n_errors++;
			test_done();
		end
	end

	initial begin
		void'($urandom(85));
		repeat (5) @(posedge i_clk);
		i_rst <= 1'b0;
		@(negedge i_clk);
		chk({1'b0, ac}, 8'h00);
		chk({2'b0, sh}, 8'h00);
		chk({gsel, don, con, blink, bw, two, br}, 8'h0c);
		b = 8'($urandom);
		// Back-to-back burst across both line wraps
		u_host_model.xfer(1'b0, 1'b1, 8'ha7);
		u_host_model.xfer(1'b1, 1'b1, b);
		u_host_model.xfer(1'b0, 1'b1, 8'he7);
		u_host_model.xfer(1'b1, 1'b1, ~b);
		u_host_model.idle();
		@(negedge i_clk);
		chk({1'b0, ac}, 8'h00);
		w(0, 8'ha7);
		r(1, b);
		chk({1'b0, ac}, 8'h40);
		w(0, 8'h04);
		r(1, 8'h20);
		chk({1'b0, ac}, 8'h27);
		w(0, 8'he7);
		r(1, ~b);
		w(0, 8'h80);
		r(1, 8'h20);
		chk({1'b0, ac}, 8'h67);
		r(0, 8'h67);
		w(0, 8'h05);
		w(1, b);
		chk({2'b0, sh}, 8'h27);
		r(1, 8'h20);
		chk({2'b0, sh}, 8'h27);
		w(0, 8'h07);
		w(1, b);
		chk({2'b0, sh}, 8'h00);
		g = 8'($urandom);
		w(0, 8'h7f);
		w(1, g);
		chk({gsel, ac}, 8'h80);
		chk({2'b0, sh}, 8'h00);
		w(0, 8'h04);
		w(1, ~g);
		chk({gsel, ac}, 8'hbf);
		w(0, 8'h40);
		w(0, 8'h14);
		chk({gsel, ac}, 8'h01);
		w(0, 8'h10);
		chk({1'b0, ac}, 8'h00);
		w(0, 8'h1f);
		chk({1'b0, sh, ac[0]}, 8'h4f);
		w(0, 8'h18);
		chk({2'b0, sh}, 8'h00);
		w(0, 8'h1c);
		w(0, 8'h01);
		chk({gsel, ac}, 8'h00);
		chk({2'b0, sh}, 8'h00);
		r(1, 8'h20);
		chk({1'b0, ac}, 8'h01);
		w(0, 8'h7f);
		r(1, g);
		w(0, 8'h1c);
		w(0, 8'h03);
		chk({1'b0, sh, ac[0]}, 8'h00);
		w(0, 8'h00);
		chk({1'b0, ac}, 8'h00);
		chk({gsel, don, con, blink, bw, two, br}, 8'h0c);
		for (k = 0; k < 8; k++) begin
			w(0, 8'(8 + k));
			chk({6'h00, don, con}, 8'(k >> 1));
		end
		cnt = 0;
		repeat (16) begin
			@(negedge i_clk);
			cnt += int'(blink);
		end
		chk(8'(cnt), 8'h08);
		w(0, 8'h0e);
		chk({7'h00, blink}, 8'h00);
		for (k = 0; k < 4; k++) begin
			w(0, 8'(8'h3c + k));
			chk({6'h00, br}, 8'(k));
			cnt = 0;
			repeat (8) begin
				@(negedge i_clk);
				cnt += int'(gate);
			end
			chk(8'(cnt), 8'(8 - 2 * k));
		end
		w(0, 8'h20);
		chk({6'h00, bw, two}, 8'h00);
		w(0, 8'h80);
		w(1, b);
		chk({1'b0, ac}, 8'h01);
		w(0, 8'h80);
		r(1, b);
		w(0, 8'h38);
		chk({6'h00, bw, two}, 8'h03);
		test_done();
	end
endmodule
